// >>> hw/mwa_regs.sv
// register windows into eeprom, shadow sram and rom, plus unlock and copy
// assumes an i2c target engine on core_clk_i giving start/stop and byte strobes
`timescale 1ns/100ps
module mwa_regs #(
  parameter int PROG_CYCLES = mwa_pkg::PROG_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic txn_start_i,
  input wire logic txn_stop_i,
  input wire logic wr_byte_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_req_i,
  output logic [7:0] rd_data_o,
  input wire logic [mwa_pkg::CAP_W-1:0] cap_code_i,
  output logic [mwa_pkg::NV_AW-1:0] nv_addr_o,
  input wire logic [7:0] nv_rdata_i,
  output logic [mwa_pkg::PTR_W-1:0] rom_addr_o,
  input wire logic [7:0] rom_rdata_i,
  output logic prog_start_o,
  output logic busy_o,
  output logic [mwa_pkg::COPY_W-1:0] copy_idx_o,
  input wire logic [7:0] copy_data_i
);
  logic [7:0] reg_ptr;
  logic addr_phase;
  logic locked;
  logic [mwa_pkg::PTR_W-1:0] mem_idx;
  logic [mwa_pkg::PTR_W-1:0] start_ptr;
  logic [7:0] unlock_key;
  logic [mwa_pkg::PAGE_W-1:0] page_sel;
  logic txn_open;
  logic key_seen;
  logic armed;
  logic busy;
  logic [mwa_pkg::PROG_CNT_W-1:0] prog_cnt;
  logic copying;
  logic [mwa_pkg::COPY_W-1:0] copy_idx;

  wire data_wr = wr_byte_i && !addr_phase;
  wire access = data_wr || rd_req_i;
  wire hit_ee = reg_ptr == mwa_pkg::ADDR_EE_WIN;
  wire hit_sram = reg_ptr == mwa_pkg::ADDR_SRAM_WIN;
  wire hit_rom = reg_ptr == mwa_pkg::ADDR_ROM_WIN;
  wire hit_win = hit_ee || hit_sram || hit_rom;
  wire txn_edge = txn_start_i || txn_stop_i;
  // first window access takes the start pointer
  // every later access steps one location on
  wire [mwa_pkg::PTR_W-1:0] acc_addr = locked ? mem_idx + 1'b1 : start_ptr;
  // the nonvolatile arrays see only the low nine bits
  wire [mwa_pkg::NV_AW-1:0] nv_addr = acc_addr[mwa_pkg::NV_AW-1:0];
  wire wr_ctrl = data_wr && reg_ptr == mwa_pkg::ADDR_NV_CTRL;
  // program only when the last data byte of the previous transaction wrote the key
  wire prog_go = wr_ctrl && wr_data_i[mwa_pkg::PROG_BIT] && armed && !busy;
  wire copy_go = wr_ctrl && wr_data_i[mwa_pkg::COPY_BIT] && !copying;
  // only the sram window stores write data; others store nothing
  wire sram_i2c_wr = data_wr && hit_sram;
  // the copy yields a cycle to a host sram write rather than dropping it
  wire copy_step = copying && !sram_i2c_wr;
  // page picks the destination region of the copy
  wire [mwa_pkg::NV_AW-1:0] copy_dst =
    mwa_pkg::NV_AW'(int'(page_sel) * mwa_pkg::COPY_BYTES + int'(copy_idx));
  wire copy_last = copy_idx == mwa_pkg::COPY_W'(mwa_pkg::COPY_BYTES - 1);
  wire sram_we = sram_i2c_wr || copy_step;
  wire [mwa_pkg::NV_AW-1:0] sram_waddr = sram_i2c_wr ? nv_addr : copy_dst;
  wire [7:0] sram_wdata = sram_i2c_wr ? wr_data_i : copy_data_i;
  wire [7:0] sram_rdata;
  logic [7:0] ctrl_rd;
  logic [7:0] rd_mux;

  mwa_shadow_sram u_sram (
    .core_clk_i(core_clk_i),
    .ce_i(ce_i),
    .we_i(sram_we),
    .waddr_i(sram_waddr),
    .wdata_i(sram_wdata),
    .raddr_i(nv_addr),
    .rdata_o(sram_rdata)
  );

  // register pointer, window lock and memory index
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_ptr <= mwa_pkg::RST_BYTE;
      addr_phase <= 1'b0;
      locked <= 1'b0;
      mem_idx <= '0;
    end else if (ce_i) begin
      // lock is dropped at every transaction boundary
      if (txn_edge) begin
        locked <= 1'b0;
        addr_phase <= txn_start_i;
      end else if (wr_byte_i && addr_phase) begin
        reg_ptr <= wr_data_i;
        addr_phase <= 1'b0;
      end else if (access && hit_win) begin
        // pointer pinned on the window once accessed
        locked <= 1'b1;
        mem_idx <= acc_addr;
      end else if (access) begin
        reg_ptr <= reg_ptr + 8'h01;
      end
    end
  end

  // host-writable registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      start_ptr <= '0;
      unlock_key <= mwa_pkg::RST_BYTE;
      page_sel <= '0;
    end else if (ce_i && data_wr) begin
      case (reg_ptr)
        mwa_pkg::ADDR_PTR_HI: start_ptr[mwa_pkg::PTR_W-1:8] <= wr_data_i[3:0];
        mwa_pkg::ADDR_PTR_LO: start_ptr[7:0] <= wr_data_i;
        mwa_pkg::ADDR_UNLOCK: unlock_key <= wr_data_i;
        mwa_pkg::ADDR_PAGE: page_sel <= wr_data_i[mwa_pkg::PAGE_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // unlock tracking across transactions
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      txn_open <= 1'b0;
      key_seen <= 1'b0;
      armed <= 1'b0;
    end else if (ce_i) begin
      if (txn_edge) begin
        // arming reflects only the transaction that just closed
        if (txn_open) begin
          armed <= key_seen;
        end
        key_seen <= 1'b0;
        txn_open <= txn_start_i;
      end else if (data_wr) begin
        key_seen <= reg_ptr == mwa_pkg::ADDR_UNLOCK && wr_data_i == mwa_pkg::UNLOCK_KEY;
      end
    end
  end

  // program cycle timer
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      prog_cnt <= '0;
      prog_start_o <= 1'b0;
    end else if (ce_i) begin
      prog_start_o <= prog_go;
      // start bit is never stored, busy runs for the cycle time
      if (prog_go) begin
        busy <= 1'b1;
        prog_cnt <= mwa_pkg::PROG_CNT_W'(PROG_CYCLES - 1);
      end else if (busy && prog_cnt == '0) begin
        busy <= 1'b0;
      end else if (busy) begin
        prog_cnt <= prog_cnt - 1'b1;
      end
    end
  end

  // register-to-sram copy walker
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      copying <= 1'b0;
      copy_idx <= '0;
    end else if (ce_i) begin
      if (copy_go) begin
        copying <= 1'b1;
        copy_idx <= '0;
      end else if (copy_step) begin
        // copy bit clears after the last byte
        copying <= !copy_last;
        copy_idx <= copy_idx + 1'b1;
      end
    end
  end

  always_comb begin
    ctrl_rd = mwa_pkg::RST_BYTE;
    ctrl_rd[mwa_pkg::COPY_BIT] = copying;
    ctrl_rd[mwa_pkg::BUSY_BIT] = busy;
  end

  always_comb begin
    case (reg_ptr)
      // eeprom cannot be reached while a program cycle runs
      mwa_pkg::ADDR_EE_WIN: rd_mux = busy ? mwa_pkg::RST_BYTE : nv_rdata_i;
      mwa_pkg::ADDR_SRAM_WIN: rd_mux = sram_rdata;
      mwa_pkg::ADDR_ROM_WIN: rd_mux = rom_rdata_i;
      mwa_pkg::ADDR_NV_CTRL: rd_mux = ctrl_rd;
      mwa_pkg::ADDR_PTR_HI: rd_mux = {4'h0, start_ptr[mwa_pkg::PTR_W-1:8]};
      mwa_pkg::ADDR_PTR_LO: rd_mux = start_ptr[7:0];
      mwa_pkg::ADDR_UNLOCK: rd_mux = unlock_key;
      mwa_pkg::ADDR_PAGE: rd_mux = {4'h0, page_sel};
      // cap code split over two read-only registers
      mwa_pkg::ADDR_CAP_HI: rd_mux = {6'h00, cap_code_i[mwa_pkg::CAP_W-1:8]};
      mwa_pkg::ADDR_CAP_LO: rd_mux = cap_code_i[7:0];
      default: rd_mux = mwa_pkg::RST_BYTE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_data_o <= mwa_pkg::RST_BYTE;
    end else if (ce_i && rd_req_i) begin
      rd_data_o <= rd_mux;
    end
  end

  assign nv_addr_o = nv_addr;
  assign rom_addr_o = acc_addr;
  assign busy_o = busy;
  assign copy_idx_o = copy_idx;
endmodule : mwa_regs

// >>> hw/mwa_pkg.sv
// constants of the memory window access register block
// assumes a byte-level i2c target engine on the same clock in front of it
package mwa_pkg;
  localparam logic [7:0] ADDR_NV_CTRL = 8'h89;
  localparam logic [7:0] ADDR_PTR_HI = 8'h8b;
  localparam logic [7:0] ADDR_PTR_LO = 8'h8c;
  localparam logic [7:0] ADDR_EE_WIN = 8'h8d;
  localparam logic [7:0] ADDR_SRAM_WIN = 8'h8e;
  localparam logic [7:0] ADDR_ROM_WIN = 8'h8f;
  localparam logic [7:0] ADDR_UNLOCK = 8'h90;
  localparam logic [7:0] ADDR_PAGE = 8'h91;
  localparam logic [7:0] ADDR_CAP_HI = 8'hc7;
  localparam logic [7:0] ADDR_CAP_LO = 8'hc8;
  localparam logic [7:0] UNLOCK_KEY = 8'hea;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int PROG_BIT = 0;
  localparam int BUSY_BIT = 2;
  localparam int COPY_BIT = 6;
  localparam int PTR_W = 12;
  localparam int NV_AW = 9;
  localparam int PAGE_W = 4;
  localparam int CAP_W = 10;
  localparam int SRAM_DEPTH = 512;
  localparam int COPY_W = 6;
  localparam int COPY_BYTES = 64;
  localparam int PROG_TIME_MS = 230;
  localparam int CLK_HZ = 50_000_000;
  localparam int PROG_CYCLES = PROG_TIME_MS * (CLK_HZ / 1000);
  localparam int PROG_CNT_W = 24;
endpackage : mwa_pkg

// >>> hw/mwa_shadow_sram.sv
// shadow sram of the nonvolatile module, flip-flop storage
// assumes one write port and an asynchronous read port suffice
`timescale 1ns/100ps
module mwa_shadow_sram (
  input wire logic core_clk_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [mwa_pkg::NV_AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [mwa_pkg::NV_AW-1:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [mwa_pkg::SRAM_DEPTH];

  // contents are data, not control, so no reset is spent on them
  always_ff @(posedge core_clk_i) begin
    if (ce_i && we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem[raddr_i];
endmodule : mwa_shadow_sram

// >>> tb/mwa_regs_assertions.sv
// timing checks on the program, busy, read-data and copy outputs of mwa_regs
// assumes one clock domain and the synchronous reset of the block
`timescale 1ns/100ps
module mwa_regs_chk #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic wr_byte_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_req_i,
  input wire logic [7:0] rd_data_o,
  input wire logic prog_start_o,
  input wire logic busy_o,
  input wire logic [mwa_pkg::COPY_W-1:0] copy_idx_o
);
  logic [mwa_pkg::PROG_CNT_W-1:0] bcnt;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // counts busy cycles so the full program length can be judged at its end
  always_ff @(posedge core_clk_i) bcnt <= (rst_i || !busy_o) ? '0 : bcnt + 1'b1;
  chk_start_busy: assert property (prog_start_o |-> busy_o)
    else $error("busy low at program start");
  chk_busy_cause: assert property ($rose(busy_o) |-> prog_start_o)
    else $error("busy rose without a program start");
  chk_start_pulse: assert property (prog_start_o |=> !prog_start_o)
    else $error("program start longer than one cycle");
  chk_busy_min: assert property (prog_start_o |-> busy_o [*8])
    else $error("busy dropped too early");
  // busy rises with the start pulse and stands exactly PROG_CYCLES cycles
  chk_busy_len: assert property ($fell(busy_o) |-> bcnt == mwa_pkg::PROG_CNT_W'(PROG_CYCLES))
    else $error("busy length wrong");
  chk_prog_write: assert property (prog_start_o |->
    $past(wr_byte_i && wr_data_i[mwa_pkg::PROG_BIT]))
    else $error("program start without a start write");
  chk_prog_idle: assert property (prog_start_o |-> !$past(busy_o))
    else $error("program restarted while busy");
  chk_rd_hold: assert property (!rd_req_i |=> $stable(rd_data_o))
    else $error("read data changed without a read");
  chk_copy_step: assert property ($changed(copy_idx_o) |->
    copy_idx_o == $past(copy_idx_o) + 1'b1 || copy_idx_o == '0)
    else $error("copy index skipped");
endmodule : mwa_regs_chk
bind mwa_regs mwa_regs_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.core_clk_i(core_clk_i),
  .rst_i(rst_i), .wr_byte_i(wr_byte_i), .wr_data_i(wr_data_i), .rd_req_i(rd_req_i),
  .rd_data_o(rd_data_o), .prog_start_o(prog_start_o), .busy_o(busy_o),
  .copy_idx_o(copy_idx_o));

// >>> tb/mwa_far_model.sv
// far-side memories: eeprom and rom contents and the copy source registers
// answers combinationally on the block's clock
`timescale 1ns/100ps
module mwa_far_model (
  input wire logic [mwa_pkg::NV_AW-1:0] nv_addr_i,
  output logic [7:0] nv_rdata_o,
  input wire logic [mwa_pkg::PTR_W-1:0] rom_addr_i,
  output logic [7:0] rom_rdata_o,
  input wire logic [mwa_pkg::COPY_W-1:0] copy_idx_i,
  output logic [7:0] copy_data_o
);
  // patterns differ between neighbouring addresses so an off-by-one read shows up
  assign nv_rdata_o = nv_addr_i[7:0] ^ {7'h00, nv_addr_i[8]} ^ 8'h5a;
  assign rom_rdata_o = rom_addr_i[7:0] + {4'h0, rom_addr_i[11:8]} + 8'h33;
  assign copy_data_o = {2'h0, copy_idx_i} + 8'h40;
endmodule : mwa_far_model

// >>> tb/mwa_regs_tb.sv
// self-checking bench for mwa_regs acting as the i2c target byte engine
// assumes the far-side memory model answers combinationally
`timescale 1ns/100ps
module mwa_regs_tb;
  logic core_clk_i = 0, rst_i = 1, ts = 0, tp = 0, wb = 0, rr = 0, got = 0, prg;
  logic ce = 1, bsy;
  logic [7:0] wd = 0, rd, nd, rmd, cd;
  logic [9:0] cap = 0;
  logic [8:0] na;
  logic [11:0] ra, ptr;
  logic [5:0] ci;
  logic [7:0] q[$];
  logic [7:0] sd[3];
  int n_mismatch = 0, num_checks = 0, cyc = 0, npg = 0;
  mwa_regs #(.PROG_CYCLES(20)) dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce),
    .txn_start_i(ts), .txn_stop_i(tp), .wr_byte_i(wb), .wr_data_i(wd), .rd_req_i(rr),
    .rd_data_o(rd), .cap_code_i(cap), .nv_addr_o(na), .nv_rdata_i(nd), .rom_addr_o(ra),
    .rom_rdata_i(rmd), .prog_start_o(prg), .busy_o(bsy), .copy_idx_o(ci), .copy_data_i(cd));
  mwa_far_model mem_u (.nv_addr_i(na), .nv_rdata_o(nd), .rom_addr_i(ra),
    .rom_rdata_o(rmd), .copy_idx_i(ci), .copy_data_o(cd));
  initial forever #10 core_clk_i = ~core_clk_i;
  function automatic logic [7:0] nv(logic [8:0] a);
    return a[7:0] ^ {7'h00, a[8]} ^ 8'h5a;
  endfunction : nv
  // rom pattern taken from the full 12-bit address, so carries into the top nibble count
  function automatic logic [7:0] rom(logic [11:0] a);
    return a[7:0] + {4'h0, a[11:8]} + 8'h33;
  endfunction : rom
  task automatic chk(logic [7:0] s, logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic conclude();
    if (n_mismatch == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // c: start, stop, write byte, read request
  task automatic op(logic [3:0] c, logic [7:0] d = 8'h00);
    @(negedge core_clk_i);
    {ts, tp, wb, rr} = c;
    wd = d;
    @(negedge core_clk_i);
    {ts, tp, wb, rr} = 4'h0;
  endtask : op
  task automatic rb(logic [7:0] e);
    q.push_back(e);
    op(4'h1);
  endtask : rb
  task automatic rs(logic [7:0] a);
    op(4'h8);
    op(4'h2, a);
    op(4'h8);
  endtask : rs
  task automatic wr(logic [7:0] a, logic [7:0] d[$]);
    op(4'h8);
    op(4'h2, a);
    foreach (d[i]) op(4'h2, d[i]);
    op(4'h4);
  endtask : wr
  // read data is compared one edge after its request
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc > 1500) begin
      n_mismatch++;
      conclude();
    end
    if (got) chk(rd, q.pop_front());
    // a read strobe while the clock enable is low loads nothing
    got <= rr && ce;
    if (prg === 1'b1) npg++;
  end
  initial begin
    logic [2:0] pg;
    logic [11:0] cp;
    void'($urandom(32'he265));
    cap = 10'($urandom);
    ptr = 12'($urandom);
    foreach (sd[i]) sd[i] = 8'($urandom);
    repeat (6) @(negedge core_clk_i);
    rst_i = 0;
    rs(mwa_pkg::ADDR_UNLOCK);
    rb(8'h00);
    rb(8'h00);
    rs(mwa_pkg::ADDR_CAP_HI);
    rb({6'h00, cap[9:8]});
    rb(cap[7:0]);
    wr(mwa_pkg::ADDR_PTR_HI, '{{4'h0, ptr[11:8]}, ptr[7:0]});
    wr(mwa_pkg::ADDR_SRAM_WIN, '{sd[0], sd[1], sd[2]});
    rs(mwa_pkg::ADDR_SRAM_WIN);
    foreach (sd[i]) rb(sd[i]);
    rs(mwa_pkg::ADDR_PTR_LO);
    rb(ptr[7:0]);
    for (int i = 0; i < 3; i++) rb(nv(ptr[8:0] + 9'(i)));
    op(4'h8);
    rb(nv(ptr[8:0]));
    // a frozen read must neither load data nor advance the eeprom address
    ce = 0;
    op(4'h1);
    ce = 1;
    rb(nv(ptr[8:0] + 9'h001));
    rs(mwa_pkg::ADDR_ROM_WIN);
    for (int i = 0; i < 3; i++) rb(rom(ptr + 12'(i)));
    op(4'h4);
    wr(mwa_pkg::ADDR_UNLOCK, '{8'h13});
    wr(mwa_pkg::ADDR_NV_CTRL, '{8'h01});
    wr(mwa_pkg::ADDR_UNLOCK, '{mwa_pkg::UNLOCK_KEY});
    wr(mwa_pkg::ADDR_PAGE, '{8'h00});
    wr(mwa_pkg::ADDR_NV_CTRL, '{8'h01});
    chk(8'(npg), 8'h00);
    // key written in the transaction right before the start
    wr(mwa_pkg::ADDR_UNLOCK, '{mwa_pkg::UNLOCK_KEY});
    wr(mwa_pkg::ADDR_NV_CTRL, '{8'h01});
    chk(8'(bsy), 8'h01);
    rs(mwa_pkg::ADDR_EE_WIN);
    rb(8'h00);
    // busy bit up, start bit reads zero as it is never stored
    rs(mwa_pkg::ADDR_NV_CTRL);
    rb(8'h04);
    op(4'h4);
    repeat (30) @(negedge core_clk_i);
    chk(8'(npg), 8'h01);
    chk(8'(bsy), 8'h00);
    pg = 3'($urandom_range(5));
    wr(mwa_pkg::ADDR_PAGE, '{{5'h00, pg}});
    wr(mwa_pkg::ADDR_NV_CTRL, '{8'h40});
    rs(mwa_pkg::ADDR_NV_CTRL);
    rb(8'h40);
    op(4'h4);
    repeat (80) @(negedge core_clk_i);
    rs(mwa_pkg::ADDR_NV_CTRL);
    rb(8'h00);
    op(4'h4);
    cp = {3'h0, pg, 6'h05};
    wr(mwa_pkg::ADDR_PTR_HI, '{{4'h0, cp[11:8]}, cp[7:0]});
    rs(mwa_pkg::ADDR_SRAM_WIN);
    rb(8'h45);
    rb(8'h46);
    op(4'h4);
    conclude();
  end
endmodule : mwa_regs_tb
